/* File: logic/sgc_pkg.sv */
package sgc_pkg;
  localparam int unsigned WORD_W          = 8;
  localparam logic [7:0]  GAIN_RESET_CODE = 8'h01;
  localparam int          GAIN_MIN_DB     = -28;
  localparam int          GAIN_MAX_DB     = 31;
  localparam int          GAIN_STEP_DB    = 1;
  localparam logic [7:0]  GAIN_CODE_MAX   = 8'h3b;
  localparam int unsigned SYNC_STAGES     = 2;
endpackage : sgc_pkg

/* File: logic/sgc_sync.sv */
`timescale 1ns/1ps
// two-flop level synchroniser; stage one is read only by stage two
module sgc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : sgc_sync

/* File: logic/sgc_top.sv */
`timescale 1ns/1ps
module sgc_top (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       serial_clk,
  input  wire logic       load_strobe_n,
  input  wire logic       serial_gain_in,
  input  wire logic       transmit_gate,
  input  wire logic       sleep_n,
  output logic [7:0]      gain_code,
  output logic            gain_in_range,
  output logic            amp_enable,
  output logic            powered_up,
  output logic            gain_update
);
  // link domain: shift register on serial_clk, reset only by async reset; it holds its value while the strobe is high
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [3:0] count_q;
  logic [3:0] count_d;

  always_comb begin
    shift_d = shift_q;
    count_d = count_q;
    if (!load_strobe_n) begin
      shift_d = {shift_q[6:0], serial_gain_in};
      count_d = (count_q == 4'h8) ? count_q : 4'(count_q + 4'h1);
    end
  end

  always_ff @(posedge serial_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= 8'h00;
      count_q <= 4'h0;
    end else begin
      shift_q <= shift_d;
      count_q <= count_d;
    end
  end

  // strobe rising edge captures the word in the strobe domain; the word is then
  // stable until the next rising strobe, and the system side takes it only after the synchronised toggle
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic       ltog_q;
  logic       ltog_d;

  always_comb begin
    latch_d = shift_q;
    ltog_d  = ~ltog_q;
  end

  always_ff @(posedge load_strobe_n or negedge reset_n) begin
    if (!reset_n) begin
      latch_q <= sgc_pkg::GAIN_RESET_CODE;
      ltog_q  <= 1'b0;
    end else begin
      latch_q <= latch_d;
      ltog_q  <= ltog_d;
    end
  end

  // toggle, transmit gate and sleep are crossed into clk_sys
  logic [2:0] sync_bits;

  sgc_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk      (clk_sys),
    .reset_n  (reset_n),
    .async_in ({ltog_q, transmit_gate, sleep_n}),
    .sync_out (sync_bits)
  );

  logic       tog_seen_q;
  logic       tog_seen_d;
  logic       hold_q;
  logic       hold_d;
  logic [7:0] gain_q;
  logic [7:0] gain_d;
  logic       range_q;
  logic       range_d;
  logic       amp_q;
  logic       amp_d;
  logic       pwr_q;
  logic       pwr_d;
  logic       upd_q;
  logic       upd_d;
  logic       new_word;

  function automatic logic code_ok(input logic [7:0] code);
    code_ok = (code <= sgc_pkg::GAIN_CODE_MAX);
  endfunction : code_ok

  // the toggle waits one more cycle so latch_q has settled for three clocks
  always_comb begin
    new_word   = (sync_bits[2] != tog_seen_q);
    tog_seen_d = sync_bits[2];
    hold_d     = new_word;
    gain_d     = gain_q;
    upd_d      = 1'b0;
    if (hold_q) begin
      gain_d = latch_q;
      upd_d  = 1'b1;
    end
    range_d = code_ok(gain_d);
    amp_d   = sync_bits[1] & sync_bits[0];
    pwr_d   = sync_bits[0];
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tog_seen_q <= 1'b0;
      hold_q     <= 1'b0;
      gain_q     <= sgc_pkg::GAIN_RESET_CODE;
      range_q    <= 1'b1;
      amp_q      <= 1'b0;
      pwr_q      <= 1'b0;
      upd_q      <= 1'b0;
    end else begin
      tog_seen_q <= tog_seen_d;
      hold_q     <= hold_d;
      gain_q     <= gain_d;
      range_q    <= range_d;
      amp_q      <= amp_d;
      pwr_q      <= pwr_d;
      upd_q      <= upd_d;
    end
  end

  assign gain_code     = gain_q;
  assign gain_in_range = range_q;
  assign amp_enable    = amp_q;
  assign powered_up    = pwr_q;
  assign gain_update   = upd_q;

  // marks a reset that the flops have taken, at reset_n falling or at a clock edge, so the reset check never looks at
  // flops that have not yet seen their first edge
  logic resetting_q;
  logic resetting_d;

  always_comb begin
    resetting_d = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      resetting_q <= 1'b1;
    end else begin
      resetting_q <= resetting_d;
    end
  end

  // assertions
  sequence s_word_arrives;
    hold_q;
  endsequence

  chk_gain_takes_word: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_word_arrives |=> (gain_q == $past(latch_q) && upd_q))
    else $error("gain did not take latched word");

  chk_gain_holds: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !hold_q |=> $stable(gain_q))
    else $error("gain changed without strobe rise");

  chk_pulse_single: assert property (@(posedge clk_sys) disable iff (!reset_n)
    upd_q |=> !upd_q)
    else $error("update pulse longer than one cycle");

  chk_tx_gate_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !sync_bits[1] |=> !amp_q)
    else $error("amplifier enabled with gate low");

  chk_sleep_state: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !sync_bits[0] |=> (!pwr_q && !amp_q))
    else $error("not asleep with sleep low");

  chk_wake_enable: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (sync_bits[0] && sync_bits[1]) |=> (pwr_q && amp_q))
    else $error("not enabled with both inputs high");

  chk_range_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ##1 (range_q == (gain_q <= sgc_pkg::GAIN_CODE_MAX)))
    else $error("range flag wrong");

  chk_reset_code: assert property (@(posedge clk_sys)
    $rose(reset_n) |-> (gain_q == sgc_pkg::GAIN_RESET_CODE))
    else $error("gain not 1 after reset");

  chk_shift_msb: assert property (@(posedge serial_clk) disable iff (!reset_n)
    !load_strobe_n |=> (shift_q[0] == $past(serial_gain_in) && shift_q[7:1] == $past(shift_q[6:0])))
    else $error("shift wrong");

  chk_shift_idle: assert property (@(posedge serial_clk) disable iff (!reset_n)
    load_strobe_n |=> $stable(shift_q))
    else $error("shifted with strobe high");

  // link domain: the bit count only climbs while the strobe is low
  sequence s_link_shift;
    !load_strobe_n;
  endsequence

  sequence s_link_idle;
    load_strobe_n;
  endsequence

  chk_count_limit: assert property (@(posedge serial_clk) disable iff (!reset_n)
    count_q <= 4'h8)
    else $error("bit count past eight");

  chk_count_step: assert property (@(posedge serial_clk) disable iff (!reset_n)
    (s_link_shift ##0 (count_q != 4'h8)) |=> (count_q == 4'($past(count_q) + 4'h1)))
    else $error("bit count did not advance");

  chk_count_idle: assert property (@(posedge serial_clk) disable iff (!reset_n)
    s_link_idle |=> $stable(count_q))
    else $error("bit count moved with strobe high");

  // strobe domain: each rising strobe takes the shifted word and flips the toggle
  chk_latch_word: assert property (@(posedge load_strobe_n) disable iff (!reset_n)
    1'b1 |=> (latch_q == $past(shift_q)))
    else $error("latch did not take shifted word");

  chk_latch_toggle: assert property (@(posedge load_strobe_n) disable iff (!reset_n)
    1'b1 |=> (ltog_q != $past(ltog_q)))
    else $error("toggle did not flip");

  // system domain
  sequence s_toggle_seen;
    new_word;
  endsequence

  sequence s_word_applied;
    hold_q ##1 upd_q;
  endsequence

  sequence s_asleep;
    !sync_bits[0];
  endsequence

  chk_update_follows: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_toggle_seen |=> s_word_applied)
    else $error("word not applied after toggle");

  chk_tog_tracks: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> (tog_seen_q == $past(sync_bits[2])))
    else $error("toggle tracker lags");

  chk_hold_single: assert property (@(posedge clk_sys) disable iff (!reset_n)
    hold_q |=> !hold_q)
    else $error("hold longer than one cycle");

  chk_upd_needs_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    upd_q |-> $past(hold_q))
    else $error("update without hold");

  chk_no_upd_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !hold_q |=> !upd_q)
    else $error("update with no new word");

  chk_gain_only_upd: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $changed(gain_q) |-> upd_q)
    else $error("gain changed without update pulse");

  // the word is taken across domains unsynchronised, so it must be quiet here
  chk_word_stable: assert property (@(posedge clk_sys) disable iff (!reset_n)
    hold_q |-> $stable(latch_q))
    else $error("latched word moved while taken");

  chk_latch_holds_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!load_strobe_n && !$past(load_strobe_n)) |-> $stable(latch_q))
    else $error("latched word moved with strobe low");

  chk_sleep_wins: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (s_asleep ##0 sync_bits[1]) |=> !amp_q)
    else $error("amplifier on while asleep");

  chk_amp_low_asleep: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !pwr_q |-> !amp_q)
    else $error("amplifier on while powered down");

  chk_amp_follows: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> (amp_q == ($past(sync_bits[1]) && $past(sync_bits[0]))))
    else $error("amplifier enable does not follow inputs");

  chk_power_follows: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> (pwr_q == $past(sync_bits[0])))
    else $error("power state does not follow sleep input");

  chk_range_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (gain_q > sgc_pkg::GAIN_CODE_MAX) |-> !range_q)
    else $error("range flag set for code above range");

  chk_range_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (gain_q <= sgc_pkg::GAIN_CODE_MAX) |-> range_q)
    else $error("range flag clear for code in range");

  chk_reset_outputs: assert property (@(posedge clk_sys)
    (!reset_n && resetting_q) |->
    (gain_q == sgc_pkg::GAIN_RESET_CODE && range_q && !amp_q && !pwr_q && !upd_q))
    else $error("outputs not at reset values");
endmodule : sgc_top

/* File: sim/sgc_host.sv */
`timescale 1ns/1ps
// host side of the gain link; the link clock idles low between frames
module sgc_host (
  output logic serial_clk,
  output logic load_strobe_n,
  output logic serial_gain_in
);
  initial begin
    serial_clk = 1'b0;
    load_strobe_n = 1'b1;
    serial_gain_in = 1'b0;
  end
  // sel low pulses the clock with the strobe held high
  task automatic frame(input logic [15:0] bits, input int n, input logic sel);
    load_strobe_n = ~sel;
    #16;
    for (int i = n - 1; i >= 0; i--) begin
      serial_gain_in = bits[i];
      #16 serial_clk = 1'b1;
      #16 serial_clk = 1'b0;
    end
    load_strobe_n = 1'b1;
    // a released data line must not keep showing the last bit
    serial_gain_in = ~serial_gain_in;
    #16;
  endtask : frame
endmodule : sgc_host

/* File: sim/serial_gain_control_test.sv */
`timescale 1ns/1ps
module serial_gain_control_test;
  logic       clk_sys = 1'b0;
  logic       reset_n = 1'b0;
  logic       transmit_gate = 1'b0;
  logic       sleep_n = 1'b1;
  logic       serial_clk, load_strobe_n, serial_gain_in;
  logic [7:0] gain_code, w, prev;
  logic       gain_in_range, amp_enable, powered_up, gain_update;
  logic [9:0] b10;
  logic [7:0] corner [4] = '{8'h00, 8'h3b, 8'h3c, 8'hff};
  int         bad_count = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  int         upd_seen = 0;
  always #25 clk_sys = ~clk_sys;
  sgc_host host (.serial_clk(serial_clk), .load_strobe_n(load_strobe_n), .serial_gain_in(serial_gain_in));
  sgc_top uut (.clk_sys(clk_sys), .reset_n(reset_n), .serial_clk(serial_clk), .load_strobe_n(load_strobe_n),
    .serial_gain_in(serial_gain_in), .transmit_gate(transmit_gate), .sleep_n(sleep_n), .gain_code(gain_code),
    .gain_in_range(gain_in_range), .amp_enable(amp_enable), .powered_up(powered_up), .gain_update(gain_update));
  function automatic logic [7:0] in_range(input logic [7:0] c);
    return {7'h0, c <= sgc_pkg::GAIN_CODE_MAX};
  endfunction : in_range
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // settle time covers the 3-4 cycle update latency with margin
  task automatic settle;
    repeat (10) @(negedge clk_sys);
  endtask : settle
  initial begin
    void'($urandom(32'hb53b2ddc));
    repeat (6) @(negedge clk_sys);
    reset_n = 1'b1;
    check(gain_code, 8'h01);
    check({7'h0, amp_enable}, 8'h00);
    prev = 8'h01;
    repeat (2) @(negedge clk_sys);
    for (int i = 0; i < 16; i++) begin
      w = (i < 4) ? corner[i] : 8'($urandom);
      fork
        host.frame({8'h00, w}, 8, 1'b1);
        #250 check(gain_code, prev);
      join
      settle();
      check(gain_code, w);
      check({7'h0, gain_in_range}, in_range(w));
      prev = w;
    end
    b10 = 10'($urandom);
    host.frame({6'h00, b10}, 10, 1'b1);
    settle();
    check(gain_code, b10[7:0]);
    prev = b10[7:0];
    host.frame(16'hffff, 8, 1'b0);
    host.frame(16'h0000, 0, 1'b1);
    settle();
    check(gain_code, prev);
    check(8'(upd_seen), 8'h12);
    for (int k = 0; k < 4; k++) begin
      {transmit_gate, sleep_n} = 2'(k);
      repeat (5) @(negedge clk_sys);
      check({7'h0, amp_enable}, {7'h0, k == 3});
      check({7'h0, powered_up}, {7'h0, k[0]});
    end
    tally_and_finish();
  end
  // one pulse per rising strobe; sampled away from the edge that launches it
  always @(negedge clk_sys) begin
    if (gain_update === 1'b1) begin
      upd_seen++;
    end
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
endmodule : serial_gain_control_test
